// >>> cipher_job_control_regs.sv
// Cipher job register bank: counts, pointers, key words, two data RAMs and job sequencer
`timescale 1ns/1ps
`default_nettype none
module cipher_job_control_regs #(
  parameter int unsigned RAM_WORDS = 512
) (
  input  wire logic          clk,
  input  wire logic          rst,
  cipher_reg_if.device       bus,
  output logic [255:0]       enc_key,
  output logic               encrypt_key_load_strobe,
  input  wire logic          enc_key_done,
  output logic [255:0]       dec_key,
  output logic               decrypt_key_load_strobe,
  input  wire logic          dec_key_done,
  output logic               blk_valid,
  input  wire logic          blk_ready,
  output logic               blk_decrypt,
  output logic [127:0]       blk_data,
  input  wire logic          res_valid,
  input  wire logic [127:0]  res_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    cipher_job_pkg::job_state_e st;
    logic         dec;
    logic         waiting;
    logic [6:0]   enc_cnt;
    logic [6:0]   dec_cnt;
    logic         enc_busy;
    logic         dec_busy;
    logic         enc_kp;
    logic         dec_kp;
    logic [8:0]   ptr1;
    logic [8:0]   ptr2;
    logic [1:0]   wi;
    logic [127:0] blk;
    logic [255:0] enc_key;
    logic [255:0] dec_key;
    logic         enc_ks;
    logic         dec_ks;
    logic         blk_valid;
    logic         rd_valid;
    logic [31:0]  rd_data;
  } dev_s;

  dev_s q;
  dev_s d;

  // Word-wide arrays; a 128-bit block is four consecutive words, lowest word first
  logic [31:0] plain_data_ram  [RAM_WORDS];
  logic [31:0] cipher_data_ram [RAM_WORDS];

  logic [31:0] src_word;
  logic [31:0] dst_word;
  logic [31:0] rd_mux;
  logic        plain_wr_hit;
  logic        cipher_wr_hit;
  logic        job_active;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  assign plain_wr_hit  = bus.wr_en && cipher_job_pkg::in_window(bus.wr_addr, cipher_job_pkg::PLAIN_BASE,
                                                                cipher_job_pkg::RAM_SPAN);
  assign cipher_wr_hit = bus.wr_en && cipher_job_pkg::in_window(bus.wr_addr, cipher_job_pkg::CIPHER_BASE,
                                                                cipher_job_pkg::RAM_SPAN);
  assign job_active    = (q.st != cipher_job_pkg::J_IDLE);
  // Encrypt reads plain and writes cipher; decrypt the other way round
  assign src_word      = q.dec ? cipher_data_ram[q.ptr2] : plain_data_ram[q.ptr1];
  assign dst_word      = q.blk[{q.wi, 5'h00} +: 32];

  // Read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (bus.rd_addr == cipher_job_pkg::ENC_CNT_ADDR) begin
      rd_mux = {24'h00_0000, q.enc_busy | q.enc_kp, q.enc_cnt};
    end else if (bus.rd_addr == cipher_job_pkg::DEC_CNT_ADDR) begin
      rd_mux = {24'h00_0000, q.dec_busy | q.dec_kp, q.dec_cnt};
    end else if (bus.rd_addr == cipher_job_pkg::PLAIN_PTR_ADDR) begin
      rd_mux = {23'h00_0000, q.ptr1};
    end else if (bus.rd_addr == cipher_job_pkg::CIPHER_PTR_ADDR) begin
      rd_mux = {23'h00_0000, q.ptr2};
    end else if (cipher_job_pkg::in_window(bus.rd_addr, cipher_job_pkg::PLAIN_BASE, cipher_job_pkg::RAM_SPAN)) begin
      rd_mux = plain_data_ram[bus.rd_addr[10:2]];
    end else if (cipher_job_pkg::in_window(bus.rd_addr, cipher_job_pkg::CIPHER_BASE, cipher_job_pkg::RAM_SPAN)) begin
      rd_mux = cipher_data_ram[bus.rd_addr[10:2]];
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    d        = q;
    d.enc_ks = 1'b0;
    d.dec_ks = 1'b0;
    d.rd_valid = bus.rd_en;
    if (bus.rd_en) begin
      d.rd_data = rd_mux;
    end
    // Engine acknowledge clears first so a new key write in the same cycle wins
    if (enc_key_done) begin
      d.enc_kp = 1'b0;
    end
    if (dec_key_done) begin
      d.dec_kp = 1'b0;
    end

    // Host writes; count writes are ignored while any job or that direction's own key load is in flight
    if (bus.wr_en) begin
      if (bus.wr_addr == cipher_job_pkg::ENC_CNT_ADDR && !job_active && !q.enc_kp
          && bus.wr_data[6:0] != 7'h00) begin
        d.enc_cnt  = bus.wr_data[6:0];
        d.enc_busy = 1'b1;
        d.dec      = 1'b0;
        d.st       = cipher_job_pkg::J_LOAD;
        d.wi       = 2'h0;
      end else if (bus.wr_addr == cipher_job_pkg::DEC_CNT_ADDR && !job_active && !q.dec_kp
                   && bus.wr_data[6:0] != 7'h00) begin
        d.dec_cnt  = bus.wr_data[6:0];
        d.dec_busy = 1'b1;
        d.dec      = 1'b1;
        d.st       = cipher_job_pkg::J_LOAD;
        d.wi       = 2'h0;
      end else if (bus.wr_addr == cipher_job_pkg::PLAIN_PTR_ADDR && !job_active) begin
        d.ptr1 = bus.wr_data[8:0];
      end else if (bus.wr_addr == cipher_job_pkg::CIPHER_PTR_ADDR && !job_active) begin
        d.ptr2 = bus.wr_data[8:0];
      end else if (cipher_job_pkg::in_window(bus.wr_addr, cipher_job_pkg::ENC_KEY_BASE,
                                             cipher_job_pkg::KEY_SPAN)) begin
        d.enc_key[{bus.wr_addr[4:2], 5'h00} +: 32] = bus.wr_data;
        if (bus.wr_addr[4:2] == 3'h0) begin
          d.enc_ks = 1'b1;
          d.enc_kp = 1'b1;
        end
      end else if (cipher_job_pkg::in_window(bus.wr_addr, cipher_job_pkg::DEC_KEY_BASE,
                                             cipher_job_pkg::KEY_SPAN)) begin
        d.dec_key[{bus.wr_addr[4:2], 5'h00} +: 32] = bus.wr_data;
        if (bus.wr_addr[4:2] == 3'h0) begin
          d.dec_ks = 1'b1;
          d.dec_kp = 1'b1;
        end
      end
    end

    // Job sequencer: gather four words, hand the block to the engine, store the result
    unique case (q.st)
      cipher_job_pkg::J_IDLE: begin
      end
      cipher_job_pkg::J_LOAD: begin
        d.blk[{q.wi, 5'h00} +: 32] = src_word;
        if (q.dec) begin
          d.ptr2 = q.ptr2 + 9'h001;
        end else begin
          d.ptr1 = q.ptr1 + 9'h001;
        end
        d.wi = q.wi + 2'h1;
        if (q.wi == 2'h3) begin
          d.st        = cipher_job_pkg::J_ISSUE;
          d.blk_valid = 1'b1;
          d.waiting   = 1'b0;
        end
      end
      cipher_job_pkg::J_ISSUE: begin
        // Engine result may arrive any time after the block is accepted
        if (q.blk_valid && blk_ready) begin
          d.blk_valid = 1'b0;
          d.waiting   = 1'b1;
        end
        if (q.waiting && res_valid) begin
          d.blk = res_data;
          d.wi  = 2'h0;
          d.st  = cipher_job_pkg::J_STORE;
        end
      end
      cipher_job_pkg::J_STORE: begin
        if (q.dec) begin
          d.ptr1 = q.ptr1 + 9'h001;
        end else begin
          d.ptr2 = q.ptr2 + 9'h001;
        end
        d.wi = q.wi + 2'h1;
        if (q.wi == 2'h3) begin
          d.st = cipher_job_pkg::J_LOAD;
          if (q.dec) begin
            d.dec_cnt = q.dec_cnt - 7'h01;
            if (q.dec_cnt == 7'h01) begin
              d.dec_busy = 1'b0;
              d.st       = cipher_job_pkg::J_IDLE;
            end
          end else begin
            d.enc_cnt = q.enc_cnt - 7'h01;
            if (q.enc_cnt == 7'h01) begin
              d.enc_busy = 1'b0;
              d.st       = cipher_job_pkg::J_IDLE;
            end
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers and RAM writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      q    <= '0;
      q.st <= cipher_job_pkg::J_IDLE;
    end else begin
      q <= d;
    end
  end

  // Host fill and job results share each RAM; the host is told to stay off while busy
  always_ff @(posedge clk) begin
    if (plain_wr_hit) begin
      plain_data_ram[bus.wr_addr[10:2]] <= bus.wr_data;
    end
    if (cipher_wr_hit) begin
      cipher_data_ram[bus.wr_addr[10:2]] <= bus.wr_data;
    end
    if (q.st == cipher_job_pkg::J_STORE && q.dec) begin
      plain_data_ram[q.ptr1] <= dst_word;
    end
    if (q.st == cipher_job_pkg::J_STORE && !q.dec) begin
      cipher_data_ram[q.ptr2] <= dst_word;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.rd_data              = q.rd_data;
  assign bus.rd_valid             = q.rd_valid;
  assign enc_key                  = q.enc_key;
  assign dec_key                  = q.dec_key;
  assign encrypt_key_load_strobe  = q.enc_ks;
  assign decrypt_key_load_strobe  = q.dec_ks;
  assign blk_valid                = q.blk_valid;
  assign blk_decrypt              = q.dec;
  assign blk_data                 = q.blk;

endmodule
`default_nettype wire

// >>> cipher_job_pkg.sv
// Shared constants for the cipher job register map and both ends' state machines
package cipher_job_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the register interface)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam logic [15:0] ENC_CNT_ADDR    = 16'h0000;
  localparam logic [15:0] DEC_CNT_ADDR    = 16'h0004;
  localparam logic [15:0] PLAIN_PTR_ADDR  = 16'h0008;
  localparam logic [15:0] CIPHER_PTR_ADDR = 16'h000c;
  localparam logic [15:0] ENC_KEY_BASE    = 16'h0100;
  localparam logic [15:0] DEC_KEY_BASE    = 16'h0120;
  localparam logic [15:0] KEY_SPAN        = 16'h0020;
  localparam logic [15:0] PLAIN_BASE      = 16'h1000;
  localparam logic [15:0] CIPHER_BASE     = 16'h2000;
  localparam logic [15:0] RAM_SPAN        = 16'h0800;

  // ----------------------------------------------------------------
  // Field layout of the count/status registers, plus pointer, block and key widths and the start pointer
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W    = 7;
  localparam int unsigned BUSY_BIT = 7;
  localparam int unsigned PTR_W    = 9;
  localparam int unsigned BLOCK_W  = 128;
  localparam int unsigned KEY_W    = 256;
  localparam logic [8:0]  START_PTR = 9'h000;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    J_IDLE  = 4'b0001,
    J_LOAD  = 4'b0010,
    J_ISSUE = 4'b0100,
    J_STORE = 4'b1000
  } job_state_e;

  typedef enum logic [5:0] {
    H_IDLE  = 6'b000001,
    H_PTR2  = 6'b000010,
    H_CNT   = 6'b000100,
    H_POLL  = 6'b001000,
    H_PWAIT = 6'b010000,
    H_RWAIT = 6'b100000
  } host_state_e;

  // Host command kinds
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_READ  = 2'h1;
  localparam logic [1:0] CMD_JOB   = 2'h2;

  // True when addr lies in [base, base+span)
  function automatic logic in_window(input logic [15:0] addr, input logic [15:0] base,
                                     input logic [15:0] span);
    return (addr >= base) && (addr < base + span);
  endfunction

endpackage

// >>> cipher_reg_if.sv
// Register interface joining the host processor end and the cipher job register bank
`timescale 1ns/1ps
`default_nettype none
interface cipher_reg_if;
  logic        wr_en;
  logic [15:0] wr_addr;
  logic [31:0] wr_data;
  logic        rd_en;
  logic [15:0] rd_addr;
  logic [31:0] rd_data;
  logic        rd_valid;

  modport device (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data, rd_valid);
  modport host   (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data, rd_valid);
endinterface
`default_nettype wire

// >>> cipher_job_host.sv
// Host end: raw register reads and writes plus the full start-and-poll job sequence
`timescale 1ns/1ps
`default_nettype none
module cipher_job_host (
  input  wire logic         clk,
  input  wire logic         rst,
  cipher_reg_if.host        bus,
  input  wire logic         cmd_valid,
  output logic              cmd_ready,
  input  wire logic [1:0]   cmd_kind,
  input  wire logic         cmd_decrypt,
  input  wire logic [15:0]  cmd_addr,
  input  wire logic [31:0]  cmd_wdata,
  output logic              rsp_valid,
  output logic [31:0]       rsp_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    cipher_job_pkg::host_state_e st;
    logic [15:0] cnt_addr;
    logic [6:0]  blocks;
    logic        wr_en;
    logic [15:0] wr_addr;
    logic [31:0] wr_data;
    logic        rd_en;
    logic [15:0] rd_addr;
    logic        rsp_valid;
    logic [31:0] rsp_data;
  } host_s;

  host_s q;
  host_s d;

  assign cmd_ready = (q.st == cipher_job_pkg::H_IDLE);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d           = q;
    d.wr_en     = 1'b0;
    d.rd_en     = 1'b0;
    d.rsp_valid = 1'b0;
    unique case (q.st)
      cipher_job_pkg::H_IDLE: begin
        if (cmd_valid) begin
          if (cmd_kind == cipher_job_pkg::CMD_WRITE) begin
            d.wr_en     = 1'b1;
            d.wr_addr   = cmd_addr;
            d.wr_data   = cmd_wdata;
            d.rsp_valid = 1'b1;
            d.rsp_data  = 32'h0000_0000;
          end else if (cmd_kind == cipher_job_pkg::CMD_READ) begin
            d.rd_en   = 1'b1;
            d.rd_addr = cmd_addr;
            d.st      = cipher_job_pkg::H_RWAIT;
          end else begin
            // Rewind plain pointer first, then cipher pointer, then write the count
            d.wr_en    = 1'b1;
            d.wr_addr  = cipher_job_pkg::PLAIN_PTR_ADDR;
            d.wr_data  = {23'h00_0000, cipher_job_pkg::START_PTR};
            d.blocks   = cmd_wdata[6:0];
            d.cnt_addr = cmd_decrypt ? cipher_job_pkg::DEC_CNT_ADDR : cipher_job_pkg::ENC_CNT_ADDR;
            d.st       = cipher_job_pkg::H_PTR2;
          end
        end
      end
      cipher_job_pkg::H_PTR2: begin
        d.wr_en   = 1'b1;
        d.wr_addr = cipher_job_pkg::CIPHER_PTR_ADDR;
        d.wr_data = {23'h00_0000, cipher_job_pkg::START_PTR};
        d.st      = cipher_job_pkg::H_CNT;
      end
      cipher_job_pkg::H_CNT: begin
        d.wr_en   = 1'b1;
        d.wr_addr = q.cnt_addr;
        d.wr_data = {25'h000_0000, q.blocks};
        d.st      = cipher_job_pkg::H_POLL;
      end
      cipher_job_pkg::H_POLL: begin
        d.rd_en   = 1'b1;
        d.rd_addr = q.cnt_addr;
        d.st      = cipher_job_pkg::H_PWAIT;
      end
      cipher_job_pkg::H_PWAIT: begin
        // Done only when the whole word is zero, busy and remaining count alike
        if (bus.rd_valid) begin
          if (bus.rd_data == 32'h0000_0000) begin
            d.rsp_valid = 1'b1;
            d.rsp_data  = bus.rd_data;
            d.st        = cipher_job_pkg::H_IDLE;
          end else begin
            d.st = cipher_job_pkg::H_POLL;
          end
        end
      end
      cipher_job_pkg::H_RWAIT: begin
        if (bus.rd_valid) begin
          d.rsp_valid = 1'b1;
          d.rsp_data  = bus.rd_data;
          d.st        = cipher_job_pkg::H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q    <= '0;
      q.st <= cipher_job_pkg::H_IDLE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops except cmd_ready
  // ----------------------------------------------------------------
  assign bus.wr_en   = q.wr_en;
  assign bus.wr_addr = q.wr_addr;
  assign bus.wr_data = q.wr_data;
  assign bus.rd_en   = q.rd_en;
  assign bus.rd_addr = q.rd_addr;
  assign rsp_valid   = q.rsp_valid;
  assign rsp_data    = q.rsp_data;

endmodule
`default_nettype wire

// >>> cipher_job_control_regs_checker.sv
// Concurrent checks on the register interface joining the host end and the register bank
`timescale 1ns/1ps
`default_nettype none
module cipher_job_control_regs_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wr_en,
  input wire logic [15:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic        rd_en,
  input wire logic [15:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic        rd_valid
);
  // ----------------------------------------------------------------
  // Clocking and helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Either count/status register
  function automatic logic is_cnt(input logic [15:0] a);
    return (a == cipher_job_pkg::ENC_CNT_ADDR) || (a == cipher_job_pkg::DEC_CNT_ADDR);
  endfunction

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_rd_answer;
    rd_en |=> rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");

  property p_rd_quiet;
    !rd_en |=> !rd_valid;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read answer without request");

  // Blocks still pending always come with the busy flag
  property p_busy_count;
    rd_en && is_cnt(rd_addr) |=> (rd_data[6:0] == 7'h00) || rd_data[7];
  endproperty
  a_busy_count: assert property (p_busy_count) else $error("count nonzero while busy low");

  // Key setup must show as busy; the stand-in engine finishes setup much later
  property p_key_pending;
    wr_en && (wr_addr == cipher_job_pkg::ENC_KEY_BASE) ##[1:4] rd_en && (rd_addr == cipher_job_pkg::ENC_CNT_ADDR)
      |=> rd_data[7];
  endproperty
  a_key_pending: assert property (p_key_pending) else $error("key setup not shown as busy");

  property p_unmapped;
    rd_en && (rd_addr == 16'h3000) |=> rd_data == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_poll_spacing;
    rd_en |=> !rd_en;
  endproperty
  a_poll_spacing: assert property (p_poll_spacing) else $error("reads back to back");

  property p_ptr_order;
    wr_en && (wr_addr == cipher_job_pkg::PLAIN_PTR_ADDR) |-> (wr_data == 32'h0)
      ##1 wr_en && (wr_addr == cipher_job_pkg::CIPHER_PTR_ADDR) && (wr_data == 32'h0)
      ##1 wr_en && is_cnt(wr_addr);
  endproperty
  a_ptr_order: assert property (p_ptr_order) else $error("pointer reset sequence broken");

  property p_job_poll;
    wr_en && is_cnt(wr_addr) && $past(wr_en) && ($past(wr_addr) == cipher_job_pkg::CIPHER_PTR_ADDR)
      |=> rd_en && (rd_addr == $past(wr_addr));
  endproperty
  a_job_poll: assert property (p_job_poll) else $error("job not polled on its own register");
endmodule
`default_nettype wire

// >>> tb_cipher_job_control_regs.sv
// Self-checking bench: host end and register bank joined, with a stand-in cipher engine
`timescale 1ns/1ps
`default_nettype none
module tb_cipher_job_control_regs;
  localparam logic [31:0] ENC_MASK = 32'h5a5a_0f0f;
  localparam logic [31:0] DEC_MASK = 32'h0330_c3c3;
  logic         clk         = 1'b0;
  logic         rst         = 1'b1;
  logic         cmd_valid   = 1'b0;
  logic         cmd_decrypt = 1'b0;
  logic [1:0]   cmd_kind    = 2'h0;
  logic [15:0]  cmd_addr    = 16'h0000;
  logic [31:0]  cmd_wdata   = 32'h0;
  logic         cmd_ready, rsp_valid, blk_valid, blk_decrypt, enc_stb, dec_stb;
  logic [31:0]  rsp_data;
  logic [255:0] enc_key, dec_key;
  logic [127:0] blk_data;
  logic         blk_ready    = 1'b0;
  logic         res_valid    = 1'b0;
  logic         enc_key_done = 1'b0;
  logic         dec_key_done = 1'b0;
  logic [127:0] res_data     = 128'h0;
  logic [127:0] held         = 128'h0;
  logic         acc          = 1'b0;
  logic [3:0]   ek           = 4'h0;
  logic [3:0]   dk           = 4'h0;
  int           enc_strobes  = 0;
  int           dec_strobes  = 0;
  int           num_errors   = 0;
  int           cmp_count    = 0;

  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Design ends and checker
  // ----------------------------------------------------------------
  cipher_reg_if bus_if ();
  cipher_job_control_regs i_cipher_job_control_regs (.clk(clk), .rst(rst), .bus(bus_if.device),
    .enc_key(enc_key), .encrypt_key_load_strobe(enc_stb), .enc_key_done(enc_key_done),
    .dec_key(dec_key), .decrypt_key_load_strobe(dec_stb), .dec_key_done(dec_key_done),
    .blk_valid(blk_valid), .blk_ready(blk_ready), .blk_decrypt(blk_decrypt), .blk_data(blk_data),
    .res_valid(res_valid), .res_data(res_data));
  cipher_job_host i_cipher_job_host (.clk(clk), .rst(rst), .bus(bus_if.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_decrypt(cmd_decrypt), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  cipher_job_control_regs_checker i_cipher_job_control_regs_checker (.clk(clk), .rst(rst),
    .wr_en(bus_if.wr_en), .wr_addr(bus_if.wr_addr), .wr_data(bus_if.wr_data), .rd_en(bus_if.rd_en),
    .rd_addr(bus_if.rd_addr), .rd_data(bus_if.rd_data), .rd_valid(bus_if.rd_valid));

  // ----------------------------------------------------------------
  // Engine stand-in: stalls every other cycle, masks data by direction
  // ----------------------------------------------------------------
  // Distinct masks per direction so a wrong direction flag shows in the data
  always @(posedge clk) begin
    if (rst) begin
      acc <= 1'b0;
      ek  <= 4'h0;
      dk  <= 4'h0;
    end else begin
      acc <= blk_valid && blk_ready;
      if (blk_valid && blk_ready) held <= blk_data ^ {4{blk_decrypt ? DEC_MASK : ENC_MASK}};
      ek <= enc_stb ? 4'hc : ((ek != 4'h0) ? ek - 4'h1 : ek);
      dk <= dec_stb ? 4'hc : ((dk != 4'h0) ? dk - 4'h1 : dk);
      if (enc_stb === 1'b1) enc_strobes <= enc_strobes + 1;
      if (dec_stb === 1'b1) dec_strobes <= dec_strobes + 1;
    end
  end

  always @(negedge clk) begin
    blk_ready    <= ~blk_ready;
    res_valid    <= acc;
    res_data     <= held;
    enc_key_done <= (ek == 4'h1);
    dec_key_done <= (dk == 4'h1);
  end

  // ----------------------------------------------------------------
  // Compare, command and verdict tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_key(input logic [255:0] got, input logic [255:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: key mismatch %h", $time, got);
    end
  endtask

  // Hold the command one edge, then wait for the one-cycle response
  task automatic do_cmd(input logic [1:0] kind, input logic dec, input logic [15:0] addr,
                        input logic [31:0] wdata, output logic [31:0] rdata);
    int n;
    @(negedge clk);
    cmd_valid   = 1'b1;
    cmd_kind    = kind;
    cmd_decrypt = dec;
    cmd_addr    = addr;
    cmd_wdata   = wdata;
    @(negedge clk);
    cmd_valid = 1'b0;
    for (n = 0; n < 3000 && rsp_valid !== 1'b1; n++) @(negedge clk);
    // A stale response word would otherwise pass as a finished job
    if (rsp_valid !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: no response to command", $time);
    end
    rdata = rsp_data;
  endtask

  task automatic wr(input logic [15:0] addr, input logic [31:0] data);
    logic [31:0] r;
    do_cmd(cipher_job_pkg::CMD_WRITE, 1'b0, addr, data, r);
  endtask

  task automatic rd(input logic [15:0] addr, output logic [31:0] data);
    do_cmd(cipher_job_pkg::CMD_READ, 1'b0, addr, 32'h0, data);
  endtask

  // Poll a count register until it reads zero, bounded
  task automatic poll(input logic [15:0] addr);
    logic [31:0] r;
    int n;
    r = 32'hffff_ffff;
    for (n = 0; n < 300 && r !== 32'h0; n++) rd(addr, r);
    chk(r, 32'h0);
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Word zero goes last, so the load pulse must carry all eight words
  task automatic t_keys();
    logic [255:0] exp;
    logic [31:0]  r;
    logic [15:0]  cnt;
    for (int e = 0; e < 2; e++) begin
      cnt = e ? cipher_job_pkg::DEC_CNT_ADDR : cipher_job_pkg::ENC_CNT_ADDR;
      for (int i = 7; i >= 0; i--) begin
        exp[32*i +: 32] = {8'(e), 8'(i), 16'hbeef};
        wr((e ? cipher_job_pkg::DEC_KEY_BASE : cipher_job_pkg::ENC_KEY_BASE) + 16'(4 * i), exp[32*i +: 32]);
      end
      rd(cnt, r);
      chk(r, 32'h0000_0080);
      poll(cnt);
      chk_key(e ? dec_key : enc_key, exp);
    end
    chk(32'(enc_strobes), 32'h1);
    chk(32'(dec_strobes), 32'h1);
  endtask

  // Last word of each window; plain read after the cipher write proves separation
  task automatic t_ram();
    logic [31:0] r;
    for (int i = 0; i < 8; i++) wr(cipher_job_pkg::PLAIN_BASE + 16'(4 * i), 32'hc0de_0000 + 32'(i));
    wr(16'h17fc, 32'h1111_7ff0);
    wr(16'h27fc, 32'h2222_7ff0);
    rd(16'h17fc, r);
    chk(r, 32'h1111_7ff0);
    rd(16'h27fc, r);
    chk(r, 32'h2222_7ff0);
    rd(16'h3000, r);
    chk(r, 32'h0);
  endtask

  task automatic t_encrypt();
    logic [31:0] r;
    do_cmd(cipher_job_pkg::CMD_JOB, 1'b0, 16'h0, 32'h2, r);
    chk(r, 32'h0);
    for (int i = 0; i < 8; i++) begin
      rd(cipher_job_pkg::CIPHER_BASE + 16'(4 * i), r);
      chk(r, (32'hc0de_0000 + 32'(i)) ^ ENC_MASK);
    end
  endtask

  // One block only: the fifth plain word must stay as filled
  task automatic t_decrypt();
    logic [31:0] r;
    for (int i = 0; i < 4; i++) wr(cipher_job_pkg::PLAIN_BASE + 16'(4 * i), 32'h0);
    do_cmd(cipher_job_pkg::CMD_JOB, 1'b1, 16'h0, 32'h1, r);
    chk(r, 32'h0);
    for (int i = 0; i < 5; i++) begin
      rd(cipher_job_pkg::PLAIN_BASE + 16'(4 * i), r);
      chk(r, (32'hc0de_0000 + 32'(i)) ^ ((i < 4) ? (ENC_MASK ^ DEC_MASK) : 32'h0));
    end
  endtask

  // Raw start: count and busy must read together mid-job, then clear
  task automatic t_status();
    logic [31:0] r;
    wr(cipher_job_pkg::ENC_CNT_ADDR, 32'h3);
    rd(cipher_job_pkg::ENC_CNT_ADDR, r);
    chk(r, 32'h0000_0083);
    poll(cipher_job_pkg::ENC_CNT_ADDR);
  endtask

  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_keys();
    t_ram();
    t_encrypt();
    t_decrypt();
    t_status();
    give_verdict();
  end

  // Watchdog: the scenarios need a few thousand cycles at most
  initial begin
    #300us;
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
